// ### design/event_edge.sv
`timescale 1ns/1ps
module event_edge #(
  parameter bit ACTIVE_LOW = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic level,
  output logic pulse
);
  logic active;
  logic prev;

  assign active = ACTIVE_LOW ? ~level : level;

  // starts as active so a source held through power-on gives no event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b1;
    end else begin
      prev <= active;
    end
  end

  assign pulse = active & ~prev;
endmodule // event_edge

// ### design/irq_sticky.sv
`timescale 1ns/1ps
module irq_sticky #(
  parameter int WIDTH = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] set_ev,
  input wire logic clr_we,
  input wire logic [WIDTH-1:0] clr_data,
  input wire logic mask_we,
  input wire logic [WIDTH-1:0] mask_data,
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);
  logic [WIDTH-1:0] next_status;

  // an event in the clearing cycle survives
  always_comb begin
    next_status = status & ~(clr_we ? clr_data : '0);
    next_status = next_status | set_ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      if (mask_we) begin
        mask <= mask_data;
      end
      irq <= |(next_status & (mask_we ? mask_data : mask));
    end
  end
endmodule // irq_sticky

// ### design/reset_cause_pkg.sv
package reset_cause_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CAUSE_W = 8;
  localparam int EVT_W = 3;

  // register indices, byte address is four times the index
  localparam int IDX_CAUSE = 'h8e;
  localparam int IDX_IRQ_STATUS = 'h90;
  localparam int IDX_IRQ_MASK = 'h91;
  localparam int IDX_LAST_CAUSE = 'h92;
  localparam logic [ADDR_W-1:0] ADDR_CAUSE = ADDR_W'(IDX_CAUSE * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = ADDR_W'(IDX_IRQ_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = ADDR_W'(IDX_IRQ_MASK * 4);
  localparam logic [ADDR_W-1:0] ADDR_LAST_CAUSE = ADDR_W'(IDX_LAST_CAUSE * 4);

  // reset-cause register fields
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_POR = 1;
  localparam logic POR_FLAG_RESET = 1'b0;
  localparam logic BROWNOUT_FLAG_RESET = 1'b1;

  // event bits in interrupt status and mask
  localparam int EVT_BROWNOUT = 0;
  localparam int EVT_MASTER_CLEAR = 1;
  localparam int EVT_WATCHDOG = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // device reset is held this long after its last source goes away
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_HOLD_NS = 1000;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 5;

  typedef enum logic [1:0] {
    CAUSE_POWER_ON,
    CAUSE_BROWNOUT,
    CAUSE_MASTER_CLEAR,
    CAUSE_WATCHDOG
  } cause_t;

  typedef struct packed {
    logic watchdog;
    logic master_clear;
    logic brownout;
  } reset_src_t;

endpackage

// ### design/reset_cause_status.sv
`timescale 1ns/1ps
module reset_cause_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic master_clear_n,
  input wire logic brownout_detect,
  input wire logic brownout_detect_enable,
  input wire logic watchdog_timer,
  output logic device_reset_n,
  output logic irq,
  input wire logic [reset_cause_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [reset_cause_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [reset_cause_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [reset_cause_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import reset_cause_pkg::*;

  reset_src_t src_ev;
  reset_src_t src_level;
  logic brownout_ev;
  logic por_flag;
  logic brownout_reset_flag;
  cause_t last_cause;
  logic [HOLD_W-1:0] hold_count;
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] irq_mask;

  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic aw_got;
  logic w_got;
  logic wr_go;
  logic wr_cause;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic wr_known;
  logic rd_sel_cause;

  // source edges
  event_edge #(
    .ACTIVE_LOW(1'b0)
  ) u_brownout_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(brownout_detect),
    .pulse(src_ev.brownout)
  );

  event_edge #(
    .ACTIVE_LOW(1'b1)
  ) u_master_clear_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(master_clear_n),
    .pulse(src_ev.master_clear)
  );

  event_edge #(
    .ACTIVE_LOW(1'b0)
  ) u_watchdog_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(watchdog_timer),
    .pulse(src_ev.watchdog)
  );

  // brown-out counts only while detection is enabled
  assign brownout_ev = src_ev.brownout & brownout_detect_enable;

  assign src_level.brownout = brownout_detect & brownout_detect_enable;
  assign src_level.master_clear = ~master_clear_n;
  assign src_level.watchdog = watchdog_timer;

  // write decode
  assign wr_go = aw_got & w_got & ~bvalid;
  assign wr_cause = wr_go & (aw_addr == ADDR_CAUSE) & w_strb[0];
  assign wr_irq_status = wr_go & (aw_addr == ADDR_IRQ_STATUS) & w_strb[0];
  assign wr_irq_mask = wr_go & (aw_addr == ADDR_IRQ_MASK) & w_strb[0];

  always_comb begin
    if (aw_addr == ADDR_CAUSE) begin
      wr_known = 1'b1;
    end else if (aw_addr == ADDR_IRQ_STATUS) begin
      wr_known = 1'b1;
    end else if (aw_addr == ADDR_IRQ_MASK) begin
      wr_known = 1'b1;
    end else if (aw_addr == ADDR_LAST_CAUSE) begin
      wr_known = 1'b1;
    end else begin
      wr_known = 1'b0;
    end
  end

  // power-on flag: cleared by power-on, set or cleared by a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_flag <= POR_FLAG_RESET;
    end else if (wr_cause) begin
      por_flag <= w_data[BIT_POR];
    end
  end

  // brown-out flag: a brown-out wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brownout_reset_flag <= BROWNOUT_FLAG_RESET;
    end else if (brownout_ev) begin
      brownout_reset_flag <= 1'b0;
    end else if (wr_cause) begin
      brownout_reset_flag <= w_data[BIT_BROWNOUT];
    end
  end

  // most recent reset source, brown-out first on a tie
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_cause <= CAUSE_POWER_ON;
    end else if (brownout_ev) begin
      last_cause <= CAUSE_BROWNOUT;
    end else if (src_ev.master_clear) begin
      last_cause <= CAUSE_MASTER_CLEAR;
    end else if (src_ev.watchdog) begin
      last_cause <= CAUSE_WATCHDOG;
    end
  end

  // device reset, stretched after its last source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_count <= HOLD_W'(RESET_HOLD_CYCLES);
      device_reset_n <= 1'b0;
    end else begin
      if (|src_level) begin
        hold_count <= HOLD_W'(RESET_HOLD_CYCLES);
      end else if (hold_count != '0) begin
        hold_count <= hold_count - HOLD_W'(1);
      end
      device_reset_n <= ~(|src_level) & (hold_count == '0);
    end
  end

  irq_sticky #(
    .WIDTH(EVT_W)
  ) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_ev({src_ev.watchdog, src_ev.master_clear, brownout_ev}),
    .clr_we(wr_irq_status),
    .clr_data(w_data[EVT_W-1:0]),
    .mask_we(wr_irq_mask),
    .mask_data(w_data[EVT_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_got <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_got <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read channel, upper bits of every register read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      rd_sel_cause <= 1'b0;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= RESP_OKAY;
        rd_sel_cause <= (araddr == ADDR_CAUSE);
        if (araddr == ADDR_CAUSE) begin
          rdata <= DATA_W'({por_flag, brownout_reset_flag});
        end else if (araddr == ADDR_IRQ_STATUS) begin
          rdata <= DATA_W'(irq_status);
        end else if (araddr == ADDR_IRQ_MASK) begin
          rdata <= DATA_W'(irq_mask);
        end else if (araddr == ADDR_LAST_CAUSE) begin
          rdata <= DATA_W'(last_cause);
        end else begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // checks
  chk_por_flag_low:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (por_flag == POR_FLAG_RESET) && (last_cause == CAUSE_POWER_ON))
    else $error("power-on flag not cleared by power-on");

  chk_brownout_flag_clear:
    assert property (@(posedge aclk) disable iff (!aresetn)
      brownout_ev |=> !brownout_reset_flag && (last_cause == CAUSE_BROWNOUT))
    else $error("brown-out did not clear its flag");

  chk_upper_bits_zero:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rvalid && rd_sel_cause) |-> (rdata[DATA_W-1:2] == '0))
    else $error("unimplemented cause bits read nonzero");

  chk_brownout_after_por:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> brownout_reset_flag == BROWNOUT_FLAG_RESET)
    else $error("brown-out flag off its chosen power-on value");

  chk_brownout_disabled:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (src_ev.brownout && !brownout_detect_enable && !wr_cause)
      |=> $stable(brownout_reset_flag))
    else $error("disabled brown-out changed its flag");

  chk_master_clear_holds:
    assert property (@(posedge aclk) disable iff (!aresetn)
      !master_clear_n |=> !device_reset_n ##1 !device_reset_n)
    else $error("master clear low did not hold device reset");

  chk_nonpower_cause:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (src_ev.watchdog && !src_ev.master_clear && !brownout_ev)
      |=> (last_cause == CAUSE_WATCHDOG) && !device_reset_n)
    else $error("watchdog not recorded as its own reset");

  chk_flags_kept:
    assert property (@(posedge aclk) disable iff (!aresetn)
      ((src_ev.master_clear || src_ev.watchdog) && !brownout_ev && !wr_cause)
      |=> $stable(por_flag) && $stable(brownout_reset_flag))
    else $error("non-power-up reset changed a cause flag");

  chk_irq_follows:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (brownout_ev && irq_mask[EVT_BROWNOUT] && !wr_irq_mask)
      |=> irq && irq_status[EVT_BROWNOUT])
    else $error("unmasked brown-out did not raise irq");

  chk_irq_level:
    assert property (@(posedge aclk) disable iff (!aresetn)
      irq == |(irq_status & irq_mask))
    else $error("irq does not match unmasked status");

  chk_por_flag_set:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_cause && w_data[BIT_POR]) |=> por_flag)
    else $error("software did not set the power-on flag");

  chk_por_flag_kept:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(por_flag) |-> $past(wr_cause))
    else $error("power-on flag fell without power-on or write");

  chk_brownout_flag_set:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_cause && w_data[BIT_BROWNOUT] && !brownout_ev) |=> brownout_reset_flag)
    else $error("software did not set the brown-out flag");

  chk_strobe_ignored:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && !w_strb[0] && !brownout_ev)
      |=> $stable(por_flag) && $stable(brownout_reset_flag))
    else $error("write without lane 0 changed a flag");

  chk_reset_release:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(device_reset_n) |-> ($past(hold_count) == '0) && ($past(src_level) == '0))
    else $error("device reset released too early");

  chk_write_busy:
    assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid |-> !awready && !wready)
    else $error("write channel ready while response pending");

  chk_read_busy:
    assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid |-> !arready)
    else $error("read address ready while data pending");

  chk_unmapped_read:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rvalid && (rresp == RESP_SLVERR)) |-> (rdata == '0))
    else $error("refused read returned data");

endmodule // reset_cause_status

// ### tb/reset_cause_status_test.sv
`timescale 1ns/1ps
module reset_cause_status_test;
  import reset_cause_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic master_clear_n = 1'b1;
  logic brownout_detect = 1'b0;
  logic brownout_detect_enable = 1'b0;
  logic watchdog_timer = 1'b0;
  logic device_reset_n;
  logic irq;
  logic [ADDR_W-1:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  int error_cnt = 0;
  int num_checks = 0;
  logic [3:0] strb_use = 4'hf;

  always #20 aclk = ~aclk;

  reset_cause_status u_reset_cause_status (
    .aclk(aclk), .aresetn(aresetn), .master_clear_n(master_clear_n),
    .brownout_detect(brownout_detect), .brownout_detect_enable(brownout_detect_enable),
    .watchdog_timer(watchdog_timer), .device_reset_n(device_reset_n), .irq(irq),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timeout();
    error_cnt++;
    $display("ERROR at %0t: wait ran out", $time);
    print_verdict();
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb_use;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        check(32'(bresp), 32'(er));
        bready <= 1'b0;
        done = 1'b1;
      end
      if (n > 50) timeout();
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        check(rdata, ed);
        check(32'(rresp), 32'(er));
        rready <= 1'b0;
        done = 1'b1;
      end
      if (n > 50) timeout();
    end
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    while (device_reset_n !== 1'b1) begin
      @(posedge aclk);
      n++;
      if (n > 100) timeout();
    end
  endtask

  // k: 0 brown-out, 1 master clear, 2 watchdog; source held for hold cycles
  task automatic pulse_src(input int k, input int hold);
    @(posedge aclk);
    if (k == 0) brownout_detect <= 1'b1;
    else if (k == 1) master_clear_n <= 1'b0;
    else watchdog_timer <= 1'b1;
    repeat (hold) @(posedge aclk);
    check(32'(device_reset_n), 32'(brownout_detect_enable == 1'b0 && k == 0));
    brownout_detect <= 1'b0;
    master_clear_n <= 1'b1;
    watchdog_timer <= 1'b0;
    wait_run();
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run();
    rd(ADDR_CAUSE, 32'h1, RESP_OKAY);
    rd(ADDR_LAST_CAUSE, 32'h0, RESP_OKAY);
    wr(ADDR_IRQ_MASK, 32'h7, RESP_OKAY);
    wr(ADDR_CAUSE, 32'hffff_fffc, RESP_OKAY);
    rd(ADDR_CAUSE, 32'h0, RESP_OKAY);
    wr(ADDR_CAUSE, 32'hff, RESP_OKAY);
    rd(ADDR_CAUSE, 32'h3, RESP_OKAY);
    // a write without byte lane 0 leaves the flags alone
    strb_use = 4'he;
    wr(ADDR_CAUSE, 32'h0, RESP_OKAY);
    strb_use = 4'hf;
    rd(ADDR_CAUSE, 32'h3, RESP_OKAY);
    // brown-out with detection off is ignored
    pulse_src(0, 4);
    check(32'(irq), 32'h0);
    rd(ADDR_CAUSE, 32'h3, RESP_OKAY);
    rd(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
    brownout_detect_enable <= 1'b1;
    pulse_src(0, 4);
    check(32'(irq), 32'h1);
    rd(ADDR_CAUSE, 32'h2, RESP_OKAY);
    rd(ADDR_LAST_CAUSE, 32'h1, RESP_OKAY);
    rd(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
    wr(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
    wr(ADDR_CAUSE, 32'h3, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0);
    // master clear held past the hold time
    pulse_src(1, 40);
    rd(ADDR_CAUSE, 32'h3, RESP_OKAY);
    rd(ADDR_LAST_CAUSE, 32'h2, RESP_OKAY);
    pulse_src(2, 3);
    rd(ADDR_CAUSE, 32'h3, RESP_OKAY);
    rd(ADDR_LAST_CAUSE, 32'h3, RESP_OKAY);
    rd(ADDR_IRQ_STATUS, 32'h6, RESP_OKAY);
    check(32'(irq), 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0);
    wr(ADDR_IRQ_STATUS, 32'h6, RESP_OKAY);
    rd(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
    wr(ADDR_LAST_CAUSE, 32'h0, RESP_OKAY);
    rd(ADDR_LAST_CAUSE, 32'h3, RESP_OKAY);
    wr(12'h000, 32'h3, RESP_SLVERR);
    rd(12'h000, 32'h0, RESP_SLVERR);
    // second power-on in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run();
    rd(ADDR_CAUSE, 32'h1, RESP_OKAY);
    print_verdict();
  end
endmodule // reset_cause_status_test
